// ---- core/fsw_link_if.sv ----
`timescale 1ns/10ps
interface fsw_link_if;
  logic byte_tgl;
  logic [7:0] byte_val;
  logic mid_byte;
  logic [15:0] status;
  modport link(output byte_tgl, output byte_val, output mid_byte,
               input status);
  modport core(input byte_tgl, input byte_val, input mid_byte,
               output status);
endinterface : fsw_link_if

// ---- core/fsw_pkg.sv ----
package fsw_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 18;
  localparam int UNIT_LSB = 12;
  localparam int UNIT_W = ADDR_W - UNIT_LSB;
  localparam int SR_W = 16;
  // Status bit positions
  localparam int POS_BUSY = 0;
  localparam int POS_LATCH = 1;
  localparam int BP_LSB = 2;
  localparam int BP_MSB = 6;
  localparam int POS_GUARD0 = 7;
  localparam int POS_GUARD1 = 8;
  localparam int POS_FOUR_LINE = 9;
  localparam int POS_PROG_SUSP = 10;
  localparam int POS_COMPL = 14;
  localparam int POS_ERASE_SUSP = 15;
  localparam logic [SR_W-1:0] SR1_WR_MASK = 16'h00fc;
  localparam logic [SR_W-1:0] SR2_WR_MASK = 16'h4300;
  localparam logic [SR_W-1:0] LOCK_MASK = 16'h3800;
  localparam logic [SR_W-1:0] NV_MASK = 16'h7bfc;
  // Command codes
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] READ_LOW_CMD = 8'h05;
  localparam logic [7:0] READ_HIGH_CMD = 8'h35;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h32;
  localparam logic [7:0] SMALL_UNIT_WIPE_CMD = 8'h20;
  localparam logic [7:0] BLOCK_WIPE_32_CMD = 8'h52;
  localparam logic [7:0] BLOCK_WIPE_64_CMD = 8'hd8;
  localparam logic [7:0] CHIP_WIPE_CMD_A = 8'h60;
  localparam logic [7:0] CHIP_WIPE_CMD_B = 8'hc7;
  localparam logic [7:0] RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] RESET_CMD = 8'h99;
  localparam logic [7:0] SUSPEND_CMD = 8'h75;
  localparam logic [7:0] RESUME_CMD = 8'h7a;
  // Frame lengths in bytes, and byte slots
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_SRW1 = 3'h2;
  localparam logic [2:0] LEN_SRW2 = 3'h3;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_PROG = 3'h5;
  localparam logic [2:0] LEN_MAX = 3'h7;
  localparam logic [2:0] BI_CMD = 3'h0;
  localparam logic [2:0] BIT_FIRST = 3'h1;
  localparam logic [2:0] BIT_WRAP = 3'h0;
  // Erase unit masks and protection sizes in 4KB units
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 18'h00fff;
  localparam logic [ADDR_W-1:0] BLK32_MASK = 18'h07fff;
  localparam logic [ADDR_W-1:0] BLK64_MASK = 18'h0ffff;
  localparam logic [UNIT_W:0] UNITS_ALL = 7'h40;
  localparam logic [UNIT_W:0] U_4K = 7'h01;
  localparam logic [UNIT_W:0] U_8K = 7'h02;
  localparam logic [UNIT_W:0] U_16K = 7'h04;
  localparam logic [UNIT_W:0] U_32K = 7'h08;
  localparam logic [UNIT_W:0] U_64K = 7'h10;
  localparam logic [UNIT_W:0] U_128K = 7'h20;
  typedef enum logic [2:0] {
    OP_PROGRAM, OP_SECTOR, OP_BLK32, OP_BLK64, OP_CHIP
  } fsw_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SRW, ST_ARRAY} fsw_state_e;
endpackage : fsw_pkg

// ---- core/fsw_spi_link.sv ----
`timescale 1ns/10ps
module fsw_spi_link import fsw_pkg::*; (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic srst,
  input wire logic si,
  output logic so,
  output logic so_oe,
  fsw_link_if.link lnk
);
  logic started_ff, nxt_started, first_ff, nxt_first;
  logic rd_ff, nxt_rd, hi_ff, nxt_hi, tgl_ff, nxt_tgl, done;
  logic [2:0] bit_ff, nxt_bit;
  logic [6:0] shin_ff, nxt_shin;
  logic [7:0] byte_ff, nxt_byte, out_ff, nxt_out, full;
  logic [15:0] st_s1, st_s2;
  logic so_ff, so_oe_ff, nxt_so, nxt_so_oe;

  // Bit count is not cleared by chip select, so a partial byte stays
  // visible to the core after the clock stops
  always_comb begin
    full = {shin_ff, si};
    nxt_started = 1'b1;
    nxt_bit = started_ff ? bit_ff + 3'h1 : BIT_FIRST;
    done = nxt_bit == BIT_WRAP;
    nxt_shin = full[6:0];
    nxt_byte = byte_ff;
    nxt_tgl = tgl_ff;
    nxt_first = first_ff;
    nxt_rd = rd_ff;
    nxt_hi = hi_ff;
    nxt_out = {out_ff[6:0], 1'b0};
    if (done) begin
      nxt_byte = full;
      nxt_tgl = ~tgl_ff;
      nxt_first = 1'b0;
      if (first_ff && (full == READ_LOW_CMD || full == READ_HIGH_CMD)) begin
        nxt_rd = 1'b1;
        nxt_hi = full == READ_HIGH_CMD;
      end
      if (nxt_rd) begin
        nxt_out = nxt_hi ? st_s2[15:8] : st_s2[7:0];
      end
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      started_ff <= 1'b0;
      first_ff <= 1'b1;
      rd_ff <= 1'b0;
      hi_ff <= 1'b0;
    end else begin
      started_ff <= nxt_started;
      first_ff <= nxt_first;
      rd_ff <= nxt_rd;
      hi_ff <= nxt_hi;
    end
  end

  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      bit_ff <= BIT_WRAP;
      tgl_ff <= 1'b0;
      shin_ff <= 7'h00;
      byte_ff <= 8'h00;
      out_ff <= 8'h00;
    end else begin
      bit_ff <= nxt_bit;
      tgl_ff <= nxt_tgl;
      shin_ff <= nxt_shin;
      byte_ff <= nxt_byte;
      out_ff <= nxt_out;
    end
  end

  // Status bits are independent flags, so each is synced on its own
  always_ff @(posedge sclk) begin
    st_s1 <= lnk.status;
    st_s2 <= st_s1;
  end

  always_comb begin
    nxt_so = rd_ff & out_ff[7];
    nxt_so_oe = rd_ff;
  end

  // Output changes on the falling edge, host samples on the rising one
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
      so_oe_ff <= nxt_so_oe;
    end
  end

  assign so = so_ff;
  assign so_oe = so_oe_ff;
  assign lnk.byte_tgl = tgl_ff;
  assign lnk.byte_val = byte_ff;
  assign lnk.mid_byte = bit_ff != BIT_WRAP;
endmodule : fsw_spi_link

// ---- core/fsw_top.sv ----
`timescale 1ns/10ps
// Operation
// - Complement bit inverts the decoded protected range
// - Low status byte bit layout
// - High status byte bit layout
// - Busy bit high during any write operation
// - Latch clear refuses all write commands
// - Block protect bits change only by status write
// - Reject program and erase inside protected range
// - Block protect writes blocked in hardware mode
// - Chip erase only for allowed protect settings
// - Guards zero allow status write with latch
// - Guard mode one blocks writes, pin low; the code ignores the pin in four-line mode
// - Guard mode one allows writes, pin high
// - Power cycle returns lock-down guards to zero
// - Both guards set refuse writes permanently
// - Latch set by enable, cleared by writes
module fsw_top import fsw_pkg::*; #(
  parameter int SRW_TIME_NS = 5000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic [SR_W-1:0] nv_image,
  input wire logic array_op_done,
  output logic so,
  output logic so_oe,
  output logic [7:0] status_low,
  output logic [7:0] status_high,
  output logic busy,
  output logic write_enable_latch,
  output logic array_op_valid,
  output logic [2:0] array_op_kind,
  output logic [ADDR_W-1:0] array_op_addr,
  output logic nv_store_valid,
  output logic [SR_W-1:0] nv_store_data
);
  localparam int SRW_CYC = (SRW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] SRW_LOAD = CNT_W'(SRW_CYC - 1);

  if (SRW_CYC < 1 || SRW_CYC > 2 ** CNT_W) begin : g_bad_time
    $error("fsw_top: status write time out of range");
  end

  fsw_link_if lnk ();

  fsw_spi_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .srst(srst),
    .si(si),
    .so(so),
    .so_oe(so_oe),
    .lnk(lnk)
  );

  logic cs_s1, cs_s2, cs_s3, tg_s1, tg_s2, tg_s3;
  logic mid_s1, mid_s2, wp_s1, wp_s2;

  // Third stage only forms edges; first stages feed nothing else
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
      mid_s1 <= 1'b0;
      mid_s2 <= 1'b0;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tg_s1 <= lnk.byte_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      mid_s1 <= lnk.mid_byte;
      mid_s2 <= mid_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  logic byte_ev;
  logic end_dly_ff, nxt_end_dly;
  logic [2:0] bcnt_ff, nxt_bcnt;
  logic [7:0] cmd_ff, nxt_cmd, b1_ff, nxt_b1, b2_ff, nxt_b2, b3_ff, nxt_b3;

  assign byte_ev = tg_s2 ^ tg_s3;

  // End is judged a cycle late so a last byte racing it is captured
  always_comb begin
    nxt_end_dly = cs_s2 & ~cs_s3;
    nxt_bcnt = bcnt_ff;
    nxt_cmd = cmd_ff;
    nxt_b1 = b1_ff;
    nxt_b2 = b2_ff;
    nxt_b3 = b3_ff;
    if (end_dly_ff) begin
      nxt_bcnt = BI_CMD;
    end else if (byte_ev) begin
      case (bcnt_ff)
        BI_CMD: nxt_cmd = lnk.byte_val;
        LEN_ONE: nxt_b1 = lnk.byte_val;
        LEN_SRW1: nxt_b2 = lnk.byte_val;
        LEN_SRW2: nxt_b3 = lnk.byte_val;
        default: ;
      endcase
      if (bcnt_ff != LEN_MAX) begin
        nxt_bcnt = bcnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      end_dly_ff <= 1'b0;
      bcnt_ff <= BI_CMD;
      cmd_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
    end else begin
      end_dly_ff <= nxt_end_dly;
      bcnt_ff <= nxt_bcnt;
      cmd_ff <= nxt_cmd;
      b1_ff <= nxt_b1;
      b2_ff <= nxt_b2;
      b3_ff <= nxt_b3;
    end
  end

  function automatic logic prot_hit(input logic [UNIT_W-1:0] u,
                                    input logic [4:0] bp,
                                    input logic cmp);
    logic none, all, upper, base;
    logic [UNIT_W:0] size;
    none = 1'b0;
    all = 1'b0;
    upper = ~bp[3];
    size = U_4K;
    if (!bp[4]) begin
      none = bp[1:0] == 2'b00;
      all = bp[1:0] == 2'b11;
      size = bp[1] ? U_128K : U_64K;
    end else begin
      none = bp[2:0] == 3'b000;
      all = bp[2:0] == 3'b111;
      case (bp[2:0])
        3'b001: size = U_4K;
        3'b010: size = U_8K;
        3'b011: size = U_16K;
        default: size = U_32K;
      endcase
    end
    if (all) begin
      base = 1'b1;
    end else if (none) begin
      base = 1'b0;
    end else if (upper) begin
      base = {1'b0, u} >= (UNITS_ALL - size);
    end else begin
      base = {1'b0, u} < size;
    end
    return base ^ cmp;
  endfunction : prot_hit

  fsw_state_e st_ff, nxt_st;
  fsw_op_e op_kind_ff, nxt_op_kind, kind;
  logic [SR_W-1:0] nv_ff, nxt_nv, status_ff, nxt_status, srw_val;
  logic [SR_W-1:0] nvs_data_ff, nxt_nvs_data;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0] op_addr_ff, nxt_op_addr, addr, amask, first_a, last_a;
  logic [23:0] raw_addr;
  logic [4:0] bp;
  logic [1:0] guard;
  logic load_ff, wel_ff, nxt_wel, esus_ff, nxt_esus, psus_ff, nxt_psus;
  logic arm_ff, nxt_arm, op_v_ff, nxt_op_v, nvs_v_ff, nxt_nvs_v;
  logic idle, frame_ok, wp_eff, sr_allowed, srw_req, srw_go;
  logic arr_req, arr_go, hit, chip_ok, short_frame;

  assign raw_addr = {b1_ff, b2_ff, b3_ff};
  assign addr = raw_addr[ADDR_W-1:0];
  assign bp = nv_ff[BP_MSB:BP_LSB];
  assign guard = {nv_ff[POS_GUARD1], nv_ff[POS_GUARD0]};
  assign idle = st_ff == ST_IDLE;
  // partial last byte voids the frame
  assign frame_ok = end_dly_ff & ~mid_s2 & ~load_ff;
  assign short_frame = bcnt_ff == LEN_ONE;
  // Four-line mode repurposes the pin, so it cannot lock
  assign wp_eff = wp_s2 | nv_ff[POS_FOUR_LINE];
  // guards 00 need only the latch
  // guard mode 01 needs pin high or four-line mode
  assign sr_allowed = wel_ff & ((guard == 2'b00) | (guard == 2'b01 & wp_eff));
  assign srw_req = cmd_ff == STATUS_WRITE_CMD &&
                   (bcnt_ff == LEN_SRW1 || bcnt_ff == LEN_SRW2);
  assign srw_go = frame_ok & idle & srw_req & sr_allowed;

  always_comb begin
    arr_req = 1'b0;
    kind = OP_PROGRAM;
    amask = '0;
    case (cmd_ff)
      PAGE_WRITE_CMD, QUAD_PAGE_WRITE_CMD: arr_req = bcnt_ff >= LEN_PROG;
      SMALL_UNIT_WIPE_CMD: begin
        arr_req = bcnt_ff == LEN_ADDR;
        kind = OP_SECTOR;
        amask = SECTOR_MASK;
      end
      BLOCK_WIPE_32_CMD: begin
        arr_req = bcnt_ff == LEN_ADDR;
        kind = OP_BLK32;
        amask = BLK32_MASK;
      end
      BLOCK_WIPE_64_CMD: begin
        arr_req = bcnt_ff == LEN_ADDR;
        kind = OP_BLK64;
        amask = BLK64_MASK;
      end
      CHIP_WIPE_CMD_A, CHIP_WIPE_CMD_B: begin
        arr_req = short_frame;
        kind = OP_CHIP;
      end
      default: ;
    endcase
  end

  assign first_a = addr & ~amask;
  assign last_a = addr | amask;
  // both ends checked, protected range always touches an end
  assign hit = prot_hit(first_a[ADDR_W-1:UNIT_LSB], bp, nv_ff[POS_COMPL]) |
               prot_hit(last_a[ADDR_W-1:UNIT_LSB], bp, nv_ff[POS_COMPL]);
  assign chip_ok = (bp[2:0] == 3'b000 & ~nv_ff[POS_COMPL]) |
                   (bp[2:0] == 3'b111 & nv_ff[POS_COMPL]);
  assign arr_go = frame_ok & idle & arr_req & wel_ff &
                  (kind == OP_CHIP ? chip_ok : ~hit);

  always_comb begin
    srw_val = (nv_ff & ~SR1_WR_MASK) | ({8'h00, b1_ff} & SR1_WR_MASK);
    if (bcnt_ff == LEN_SRW2) begin
      srw_val = (srw_val & ~SR2_WR_MASK) | ({b2_ff, 8'h00} & SR2_WR_MASK) |
                ({b2_ff, 8'h00} & LOCK_MASK);
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_nv = nv_ff;
    nxt_wel = wel_ff;
    nxt_esus = esus_ff;
    nxt_psus = psus_ff;
    nxt_arm = frame_ok ? 1'b0 : arm_ff;
    nxt_cnt = cnt_ff;
    nxt_op_v = 1'b0;
    nxt_op_kind = op_kind_ff;
    nxt_op_addr = op_addr_ff;
    nxt_nvs_v = 1'b0;
    nxt_nvs_data = nvs_data_ff;
    if (load_ff) begin
      nxt_nv = nv_image & NV_MASK;
      // lock-down guards return to zero on power up
      if (nv_image[POS_GUARD1] && !nv_image[POS_GUARD0]) begin
        nxt_nv[POS_GUARD1] = 1'b0;
      end
    end
    case (st_ff)
      ST_IDLE: begin
        if (frame_ok && short_frame) begin
          case (cmd_ff)
            // enable sets, disable clears the latch
            WRITE_ENABLE_CMD: nxt_wel = 1'b1;
            WRITE_DISABLE_CMD: nxt_wel = 1'b0;
            RESET_ARM_CMD: nxt_arm = 1'b1;
            RESET_CMD: begin
              if (arm_ff) begin
                nxt_wel = 1'b0;
                nxt_esus = 1'b0;
                nxt_psus = 1'b0;
              end
            end
            RESUME_CMD: begin
              nxt_esus = 1'b0;
              nxt_psus = 1'b0;
            end
            default: ;
          endcase
        end
        // hardware mode already refused in sr_allowed
        if (srw_go) begin
          nxt_nv = srw_val;
          nxt_st = ST_SRW;
          nxt_cnt = SRW_LOAD;
        end
        if (arr_go) begin
          nxt_st = ST_ARRAY;
          nxt_op_v = 1'b1;
          nxt_op_kind = kind;
          nxt_op_addr = first_a;
        end
      end
      // busy for the whole update, latch clears at the end
      ST_SRW: begin
        if (cnt_ff == '0) begin
          nxt_st = ST_IDLE;
          nxt_wel = 1'b0;
          nxt_nvs_v = 1'b1;
          nxt_nvs_data = nv_ff;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      ST_ARRAY: begin
        if (frame_ok && short_frame && cmd_ff == SUSPEND_CMD) begin
          nxt_psus = op_kind_ff == OP_PROGRAM;
          nxt_esus = op_kind_ff != OP_PROGRAM;
        end
        // latch clears when the array operation ends
        if (array_op_done) begin
          nxt_st = ST_IDLE;
          nxt_wel = 1'b0;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // busy bit follows any write operation
    nxt_status = nv_ff;
    nxt_status[POS_BUSY] = st_ff != ST_IDLE;
    nxt_status[POS_LATCH] = wel_ff;
    nxt_status[POS_PROG_SUSP] = psus_ff;
    nxt_status[POS_ERASE_SUSP] = esus_ff;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_ff <= 1'b1;
      st_ff <= ST_IDLE;
      nv_ff <= '0;
      wel_ff <= 1'b0;
      esus_ff <= 1'b0;
      psus_ff <= 1'b0;
      arm_ff <= 1'b0;
      cnt_ff <= '0;
      op_v_ff <= 1'b0;
      op_kind_ff <= OP_PROGRAM;
      op_addr_ff <= '0;
      nvs_v_ff <= 1'b0;
      nvs_data_ff <= '0;
      status_ff <= '0;
    end else begin
      load_ff <= 1'b0;
      st_ff <= nxt_st;
      nv_ff <= nxt_nv;
      wel_ff <= nxt_wel;
      esus_ff <= nxt_esus;
      psus_ff <= nxt_psus;
      arm_ff <= nxt_arm;
      cnt_ff <= nxt_cnt;
      op_v_ff <= nxt_op_v;
      op_kind_ff <= nxt_op_kind;
      op_addr_ff <= nxt_op_addr;
      nvs_v_ff <= nxt_nvs_v;
      nvs_data_ff <= nxt_nvs_data;
      status_ff <= nxt_status;
    end
  end

  assign lnk.status = status_ff;
  assign status_low = status_ff[7:0];
  assign status_high = status_ff[15:8];
  assign busy = status_ff[POS_BUSY];
  assign write_enable_latch = status_ff[POS_LATCH];
  assign array_op_valid = op_v_ff;
  assign array_op_kind = op_kind_ff;
  assign array_op_addr = op_addr_ff;
  assign nv_store_valid = nvs_v_ff;
  assign nv_store_data = nvs_data_ff;

  busy_track_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (srw_go || arr_go) |-> ##2 busy)
    else $error("busy not raised after accepted write");
  wel_gate_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (array_op_valid || (st_ff == ST_SRW && $past(st_ff) == ST_IDLE))
    |-> $past(wel_ff))
    else $error("write started without latch");
  bp_only_srw_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (!$past(load_ff) && $changed(bp)) |-> $past(srw_go))
    else $error("protect bits changed outside status write");
  prot_reject_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && idle && arr_req && wel_ff && kind != OP_CHIP && hit)
    |=> !array_op_valid && st_ff == ST_IDLE)
    else $error("protected address accepted");
  chip_gate_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (array_op_valid && op_kind_ff == OP_CHIP) |-> $past(chip_ok))
    else $error("chip erase with wrong protect bits");
  free_write_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && idle && srw_req && wel_ff && guard == 2'b00)
    |=> st_ff == ST_SRW)
    else $error("software mode write refused");
  hw_lock_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && srw_req && guard == 2'b01 && !wp_eff)
    |=> $stable(nv_ff) && st_ff != ST_SRW)
    else $error("hardware protected write taken");
  open_write_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && idle && srw_req && wel_ff && guard == 2'b01 && wp_eff)
    |=> st_ff == ST_SRW)
    else $error("unprotected pin write refused");
  lock_down_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && srw_req && guard[1]) |=> $stable(nv_ff))
    else $error("locked status register written");
  guard_boot_a: assert property (
    @(posedge core_clk) disable iff (srst)
    $past(load_ff) |-> guard != 2'b10)
    else $error("lock-down survived power up");
  wel_set_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (frame_ok && idle && short_frame && cmd_ff == WRITE_ENABLE_CMD)
    |-> ##2 write_enable_latch)
    else $error("enable did not set latch");
  part_byte_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (end_dly_ff && mid_s2) |=> $stable(st_ff) && !array_op_valid)
    else $error("partial frame executed");
  srw_end_a: assert property (
    @(posedge core_clk) disable iff (srst)
    (srw_go ##1 (st_ff == ST_SRW)[*2]) or
    (st_ff == ST_SRW && cnt_ff == '0 ##1 !wel_ff && nv_store_valid)
    or !(srw_go || (st_ff == ST_SRW && cnt_ff == '0)))
    else $error("status update timing wrong");
endmodule : fsw_top

// ---- verification/fsw_host_model.sv ----
`timescale 1ns/10ps
module fsw_host_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // whole bytes, unless a cut frame is wanted
  task automatic frame(input logic [39:0] d, input int nb,
                       output logic [7:0] r);
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < nb; i++) begin
      si = d[39-i];
      #7.5;
      sclk = 1'b1;
      r = {r[6:0], so};
      #7.5;
      sclk = 1'b0;
    end
    #10;
    cs_n = 1'b1;
    // Released line must not look stable
    si = ~si;
    #110;
  endtask : frame
endmodule : fsw_host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import fsw_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, wp_n = 1'b1, array_op_done = 1'b0;
  logic [SR_W-1:0] nv_image = 16'h0000, nv_store_data;
  logic sclk, cs_n, si, so, so_oe, busy, write_enable_latch, array_op_valid, nv_store_valid;
  logic [7:0] status_low, status_high, rb, low, wc;
  logic [15:0] st_d;
  logic [2:0] array_op_kind, op_k;
  logic [ADDR_W-1:0] array_op_addr, op_a, a;
  int n_errors = 0, compares = 0, n_op = 0, n_st = 0, n_busy = 0, cyc = 0;
  int n_mark = 0, n_oe = 0;
  integer seed = 32'hb75a81d8;
  always #5 core_clk = ~core_clk;
  fsw_top #(.SRW_TIME_NS(50)) uut (.core_clk(core_clk), .srst(srst),
    .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .nv_image(nv_image),
    .array_op_done(array_op_done), .so(so), .so_oe(so_oe),
    .status_low(status_low), .status_high(status_high), .busy(busy),
    .write_enable_latch(write_enable_latch), .array_op_valid(array_op_valid),
    .array_op_kind(array_op_kind), .array_op_addr(array_op_addr),
    .nv_store_valid(nv_store_valid), .nv_store_data(nv_store_data));
  fsw_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  // Enable changes only on the falling edge or when chip select rises, so rising edges are safe
  always @(posedge sclk) begin
    if (so_oe === 1'b1) n_oe++;
  end
  always @(posedge core_clk) begin
    if (busy === 1'b1) n_busy++;
    if (nv_store_valid === 1'b1) begin
      n_st++;
      st_d <= nv_store_data;
    end
    if (array_op_valid === 1'b1) begin
      n_op++;
      op_a <= array_op_addr;
      op_k <= array_op_kind;
    end
    cyc++;
    // Ceiling well above the expected run
    if (cyc > 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk
  task automatic cmd(input logic [39:0] d, input int nb);
    host.frame(d, nb * 8, rb);
    repeat (20) @(negedge core_clk);
  endtask : cmd
  task automatic do_reset(input logic [15:0] nv);
    @(negedge core_clk);
    srst = 1'b1;
    nv_image = nv;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : do_reset
  task automatic srw(input logic [15:0] v, input int nb, input int ok);
    int s0;
    int b0;
    s0 = n_st;
    b0 = n_busy;
    cmd({WRITE_ENABLE_CMD, 32'h0}, 1);
    cmd({STATUS_WRITE_CMD, v, 16'h0}, nb);
    chk({17'(n_st - s0), write_enable_latch}, {17'(ok), ok == 0});
    chk(18'(n_busy > b0), 18'(ok));
  endtask : srw
  task automatic wipe(input logic [39:0] d, input int nb, input int ok);
    int n0;
    n0 = n_op;
    cmd({WRITE_ENABLE_CMD, 32'h0}, 1);
    cmd(d, nb);
    chk(18'(n_op - n0), 18'(ok));
    if (ok != 0) begin
      array_op_done = 1'b1;
      @(negedge core_clk);
      array_op_done = 1'b0;
      repeat (5) @(negedge core_clk);
    end
    chk({busy, write_enable_latch}, {1'b0, ok == 0});
  endtask : wipe
  initial begin
    do_reset(16'hffff);
    chk({status_high, status_low}, 16'h7bfc);
    srw(16'h0000, 2, 0);
    chk(status_low, 8'hfe);
    cmd({WRITE_DISABLE_CMD, 32'h0}, 1);
    chk(write_enable_latch, 1'b0);
    wipe({CHIP_WIPE_CMD_B, 32'h0}, 1, 1);
    chk(op_k, 3'h4);
    $display("test guards done");
    do_reset(16'h0000);
    cmd({STATUS_WRITE_CMD, 8'h08, 24'h0}, 2);
    chk({status_high, status_low}, 16'h0000);
    cmd({WRITE_ENABLE_CMD, 32'h0}, 1);
    n_mark = n_op;
    host.frame({BLOCK_WIPE_64_CMD, 32'h0}, 33, rb);
    repeat (20) @(negedge core_clk);
    chk({16'(n_op - n_mark), busy, write_enable_latch}, 18'h00001);
    wipe({CHIP_WIPE_CMD_A, 32'h0}, 1, 1);
    for (int i = 0; i < 4; i++) begin
      low = {1'b0, 5'($random(seed)), 2'h0};
      srw({low, 8'h00}, 2, 1);
      chk(st_d, {8'h00, low});
      n_mark = n_oe;
      host.frame({READ_LOW_CMD, 32'h0}, 16, rb);
      chk({rb, 10'(n_oe - n_mark)}, {low, 10'h008});
      wipe({CHIP_WIPE_CMD_B, 32'h0}, 1, low[4:2] == 3'h0);
    end
    $display("test chip wipe done");
    for (int c = 0; c < 2; c++) begin
      srw({8'h04, 1'b0, c[0], 6'h0}, 3, 1);
      for (int h = 0; h < 2; h++) begin
        a = {h[0] ? 6'h30 : 6'h2f, 12'($random(seed))};
        wc = h[0] ? SMALL_UNIT_WIPE_CMD : BLOCK_WIPE_32_CMD;
        wipe({wc, 6'h0, a, 8'h0}, 4, h == c);
        if (h == c) chk(op_a, a & ~(h[0] ? SECTOR_MASK : BLK32_MASK));
      end
    end
    wipe({PAGE_WRITE_CMD, 6'h0, a, 8'h5a}, 5, 1);
    chk(op_a, a);
    chk(op_k, 3'h0);
    $display("test range done");
    srw({8'h80, 8'h00}, 3, 1);
    wp_n = 1'b0;
    srw({8'h84, 8'h00}, 2, 0);
    chk(status_low, 8'h82);
    wp_n = 1'b1;
    srw({8'h84, 8'h00}, 2, 1);
    chk(status_low, 8'h84);
    srw({8'h04, 8'h01}, 3, 1);
    srw({8'h00, 8'h00}, 3, 0);
    host.frame({READ_HIGH_CMD, 32'h0}, 16, rb);
    chk(rb, 8'h01);
    cmd({RESET_ARM_CMD, 32'h0}, 1);
    cmd({RESET_CMD, 32'h0}, 1);
    chk(write_enable_latch, 1'b0);
    do_reset(16'h0104);
    chk({status_high, status_low}, 16'h0004);
    $display("test pin modes done");
    end_sim();
  end
endmodule : tb_top
